// >>> oame_defs.svh
`ifndef OAME_DEFS_SVH
`define OAME_DEFS_SVH
// ============================================================
// opcode patterns, 14-bit instruction word
`define OAME_OP_W 14
`define OAME_PAT_OR_LIT 6'h1A
`define OAME_PAT_LOAD_LIT 6'h19
`define OAME_PAT_OR_FILE 6'h04
`define OAME_PAT_COPY_FILE 7'h10
`define OAME_PAT_STORE_FILE 7'h01
`define OAME_PAT_STORE_SPEC 8'h00
// ============================================================
// field positions inside the instruction word
`define OAME_OPC_MSB 13
`define OAME_OPC6_LSB 8
`define OAME_OPC7_LSB 7
`define OAME_OPC8_LSB 6
`define OAME_LIT_MSB 7
`define OAME_DEST_BIT 7
// ============================================================
// reset values
`define OAME_ACC_RST 8'h00
`define OAME_ZERO_RST 1'h0
`endif

// >>> oame_pkg.sv
`default_nettype none
package oame_pkg;
  typedef enum logic [2:0] {
    OAME_NONE,
    OAME_OR_LIT,
    OAME_OR_FILE,
    OAME_COPY_FILE,
    OAME_LOAD_LIT,
    OAME_STORE_FILE,
    OAME_STORE_SPEC
  } oame_op_t;
endpackage
`default_nettype wire

// >>> oame_exec.sv
`timescale 1ns/10ps
`default_nettype none
`include "oame_defs.svh"

module oame_exec #(
  parameter int DATA_W = 8,
  parameter int FADDR_W = 7,
  parameter int SADDR_W = 6
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic instr_valid_in,
  input wire logic [`OAME_OP_W-1:0] instr_in,
  input wire logic [DATA_W-1:0] file_rdata_in,
  output logic [FADDR_W-1:0] file_addr_out,
  output logic file_we_out,
  output logic [DATA_W-1:0] file_wdata_out,
  output logic [SADDR_W-1:0] spec_addr_out,
  output logic spec_we_out,
  output logic [DATA_W-1:0] spec_wdata_out,
  output logic [DATA_W-1:0] acc_out,
  output logic zero_flag_out,
  output logic illegal_out
);

  // ============================================================
  // reset release
  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_reg <= 1'h0;
      rst_n_reg <= 1'h0;
    end else begin
      rst_meta_reg <= 1'h1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ============================================================
  // decode
  function automatic logic [DATA_W-1:0] or_op(input logic [DATA_W-1:0] a,
                                              input logic [DATA_W-1:0] b);
    or_op = a | b;
  endfunction

  // patterns differ in length, so each is matched on a slice of its own width
  wire logic [5:0] opc6 = instr_in[`OAME_OPC_MSB:`OAME_OPC6_LSB];
  wire logic [6:0] opc7 = instr_in[`OAME_OPC_MSB:`OAME_OPC7_LSB];
  wire logic [7:0] opc8 = instr_in[`OAME_OPC_MSB:`OAME_OPC8_LSB];

  wire logic [7:0] lit = instr_in[`OAME_LIT_MSB:0];
  wire logic dest_bit = instr_in[`OAME_DEST_BIT];
  wire logic [FADDR_W-1:0] faddr = instr_in[FADDR_W-1:0];
  wire logic [SADDR_W-1:0] saddr = instr_in[SADDR_W-1:0];

  wire logic hit_or_lit = (opc6 == `OAME_PAT_OR_LIT);
  wire logic hit_load_lit = (opc6 == `OAME_PAT_LOAD_LIT);
  wire logic hit_or_file = (opc6 == `OAME_PAT_OR_FILE);
  wire logic hit_copy_file = (opc7 == `OAME_PAT_COPY_FILE);
  wire logic hit_store_file = (opc7 == `OAME_PAT_STORE_FILE);
  wire logic hit_store_spec = (opc8 == `OAME_PAT_STORE_SPEC);

  oame_pkg::oame_op_t op;
  // store-special pattern also covers the all-zero no-op word; this block treats it as a store
  // because distinguishing the two belongs to the wider decoder
  assign op = !instr_valid_in ? oame_pkg::OAME_NONE :
    hit_or_lit ? oame_pkg::OAME_OR_LIT :
    hit_load_lit ? oame_pkg::OAME_LOAD_LIT :
    hit_or_file ? oame_pkg::OAME_OR_FILE :
    hit_copy_file ? oame_pkg::OAME_COPY_FILE :
    hit_store_file ? oame_pkg::OAME_STORE_FILE :
    hit_store_spec ? oame_pkg::OAME_STORE_SPEC :
    oame_pkg::OAME_NONE;

  wire logic [DATA_W-1:0] or_lit_res = or_op(acc_out, lit);
  wire logic [DATA_W-1:0] or_file_res = or_op(acc_out, file_rdata_in);

  // ============================================================
  // file and special register access, combinational in the same cycle
  assign file_addr_out = faddr;
  assign file_we_out = (op == oame_pkg::OAME_STORE_FILE) ||
                       (op == oame_pkg::OAME_OR_FILE && dest_bit);
  assign file_wdata_out = (op == oame_pkg::OAME_OR_FILE) ? or_file_res : acc_out;
  assign spec_addr_out = saddr;
  assign spec_we_out = (op == oame_pkg::OAME_STORE_SPEC);
  assign spec_wdata_out = acc_out;
  assign illegal_out = instr_valid_in && (op == oame_pkg::OAME_NONE);

  // ============================================================
  // accumulator and zero flag
  logic [DATA_W-1:0] acc_next;
  logic zero_next;
  always_comb begin
    acc_next = acc_out;
    zero_next = zero_flag_out;
    case (op)
      oame_pkg::OAME_OR_LIT: begin
        acc_next = or_lit_res;
        zero_next = (or_lit_res == '0);
      end
      oame_pkg::OAME_OR_FILE: begin
        if (!dest_bit) begin
          acc_next = or_file_res;
        end
        zero_next = (or_file_res == '0);
      end
      oame_pkg::OAME_COPY_FILE: acc_next = file_rdata_in;
      oame_pkg::OAME_LOAD_LIT: acc_next = lit;
      oame_pkg::OAME_STORE_FILE,
      oame_pkg::OAME_STORE_SPEC: begin
        // stores only raise a strobe; accumulator and flag hold
        acc_next = acc_out;
      end
      default: acc_next = acc_out;
    endcase
  end

  // accumulator and flag are the only state besides the two reset sync flops; file writes leave as strobes
  always_ff @(posedge clock_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      acc_out <= `OAME_ACC_RST;
      zero_flag_out <= `OAME_ZERO_RST;
    end else begin
      acc_out <= acc_next;
      zero_flag_out <= zero_next;
    end
  end

  // ============================================================
  // checks
  a_or_lit_acc: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    op == oame_pkg::OAME_OR_LIT |=> acc_out == ($past(acc_out) | $past(lit)))
    else $error("literal or result wrong");
  a_or_file_acc: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    (op == oame_pkg::OAME_OR_FILE && !dest_bit) |=>
      acc_out == ($past(acc_out) | $past(file_rdata_in)))
    else $error("file or result wrong");
  a_or_dest_zero: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    (op == oame_pkg::OAME_OR_FILE && !dest_bit) |-> !file_we_out)
    else $error("file written with dest 0");
  a_or_dest_one: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    (op == oame_pkg::OAME_OR_FILE && dest_bit) |-> file_we_out &&
      file_wdata_out == (acc_out | file_rdata_in) ##1 $stable(acc_out))
    else $error("dest 1 or wrong");
  a_copy_file: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    op == oame_pkg::OAME_COPY_FILE |=>
      acc_out == $past(file_rdata_in) && $stable(zero_flag_out))
    else $error("copy to acc wrong");
  a_load_lit: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    op == oame_pkg::OAME_LOAD_LIT |=> acc_out == $past(lit) && $stable(zero_flag_out))
    else $error("literal load wrong");
  a_store_file: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    op == oame_pkg::OAME_STORE_FILE |-> file_we_out && file_wdata_out == acc_out
      ##1 $stable(zero_flag_out))
    else $error("file store wrong");
  a_store_spec: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    op == oame_pkg::OAME_STORE_SPEC |-> spec_we_out && !file_we_out &&
      spec_wdata_out == acc_out ##1 $stable(zero_flag_out))
    else $error("special store wrong");
  a_zero_or_lit: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    op == oame_pkg::OAME_OR_LIT |=>
      zero_flag_out == (($past(acc_out) | $past(lit)) == '0))
    else $error("zero flag wrong after literal or");
  a_zero_or_file: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    op == oame_pkg::OAME_OR_FILE |=>
      zero_flag_out == (($past(acc_out) | $past(file_rdata_in)) == '0))
    else $error("zero flag wrong after file or");

  // ============================================================
  // checks: strobes only where a write is due
  a_or_lit_no_write: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    op == oame_pkg::OAME_OR_LIT |-> !file_we_out && !spec_we_out)
    else $error("literal or raised a write");
  a_or_file_spec_quiet: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    op == oame_pkg::OAME_OR_FILE |-> !spec_we_out)
    else $error("file or raised a special write");
  a_copy_no_write: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    op == oame_pkg::OAME_COPY_FILE |-> !file_we_out && !spec_we_out)
    else $error("copy raised a write");
  a_load_no_write: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    op == oame_pkg::OAME_LOAD_LIT |-> !file_we_out && !spec_we_out)
    else $error("literal load raised a write");
  a_file_we_due: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    file_we_out |->
      op == oame_pkg::OAME_STORE_FILE || (op == oame_pkg::OAME_OR_FILE && dest_bit))
    else $error("file write strobe without cause");
  a_spec_we_due: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    spec_we_out |-> op == oame_pkg::OAME_STORE_SPEC)
    else $error("special write strobe without cause");

  // ============================================================
  // checks: held state
  a_file_store_kept: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    op == oame_pkg::OAME_STORE_FILE |-> !spec_we_out ##1 $stable(acc_out))
    else $error("file store disturbed accumulator");
  a_spec_store_kept: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    op == oame_pkg::OAME_STORE_SPEC |=> $stable(acc_out))
    else $error("special store disturbed accumulator");
  a_idle_quiet: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    !instr_valid_in |-> !file_we_out && !spec_we_out && !illegal_out
      ##1 $stable(acc_out) && $stable(zero_flag_out))
    else $error("idle cycle had an effect");
  a_illegal_quiet: assert property (@(posedge clock_in) disable iff (!rst_n_reg)
    illegal_out |-> !file_we_out && !spec_we_out
      ##1 $stable(acc_out) && $stable(zero_flag_out))
    else $error("unknown word had an effect");

  // ============================================================
  // checks: reset
  // no disable here, this one watches the reset itself
  a_reset_values: assert property (@(posedge clock_in)
    !rst_n_reg |-> acc_out == `OAME_ACC_RST && zero_flag_out == `OAME_ZERO_RST)
    else $error("reset values wrong");

endmodule // oame_exec
`default_nettype wire

// >>> oame_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// bench for the six-instruction executor
module testbench;
  logic clock_in, arst_n_in, instr_valid_in, file_we_out, spec_we_out, zero_flag_out, illegal_out;
  logic [13:0] instr_in;
  logic [7:0] file_rdata_in, file_wdata_out, spec_wdata_out, acc_out;
  logic [6:0] file_addr_out;
  logic [5:0] spec_addr_out;
  int bad_count = 0;
  int n_tests = 0;
  oame_exec dut_u (.clock_in(clock_in), .arst_n_in(arst_n_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .file_rdata_in(file_rdata_in), .file_addr_out(file_addr_out),
    .file_we_out(file_we_out), .file_wdata_out(file_wdata_out), .spec_addr_out(spec_addr_out),
    .spec_we_out(spec_we_out), .spec_wdata_out(spec_wdata_out), .acc_out(acc_out),
    .zero_flag_out(zero_flag_out), .illegal_out(illegal_out));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobes are combinational, so look 1 ns after driving
  task automatic op(input logic [13:0] w, input logic [7:0] rd);
    @(negedge clock_in);
    instr_valid_in = 1'b1;
    instr_in = w;
    file_rdata_in = rd;
    #1;
  endtask
  task automatic idle;
    @(negedge clock_in);
    instr_valid_in = 1'b0;
    #1;
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic t_literal;
    op(14'h199A, 8'h00);
    op(14'h1A35, 8'h00);
    chk(acc_out, 8'h9A);
    idle;
    chk(acc_out, 8'hBF);
    chk({7'h00, zero_flag_out}, 8'h00);
    op(14'h1900, 8'h00);
    op(14'h1A00, 8'h00);
    idle;
    chk({7'h00, zero_flag_out}, 8'h01);
    op(14'h0810, 8'hC2);
    idle;
    chk(acc_out, 8'hC2);
    chk({7'h00, zero_flag_out}, 8'h01);
    op(14'h195A, 8'h00);
    idle;
    chk(acc_out, 8'h5A);
    chk({7'h00, zero_flag_out}, 8'h01);
  endtask
  task automatic t_or_file;
    op(14'h1991, 8'h00);
    op(14'h0415, 8'h13);
    chk({1'b0, file_addr_out}, 8'h15);
    chk({7'h00, file_we_out}, 8'h00);
    idle;
    chk(acc_out, 8'h93);
    op(14'h04A5, 8'h40);
    chk({7'h00, file_we_out}, 8'h01);
    chk(file_wdata_out, 8'hD3);
    idle;
    chk(acc_out, 8'h93);
  endtask
  task automatic t_store;
    op(14'h00FF, 8'h00);
    chk({file_we_out, file_addr_out}, 8'hFF);
    chk(file_wdata_out, 8'h93);
    chk({7'h00, spec_we_out}, 8'h00);
    op(14'h003F, 8'h00);
    chk({spec_we_out, file_we_out, spec_addr_out}, 8'hBF);
    chk(spec_wdata_out, 8'h93);
    op(14'h3FFF, 8'h00);
    chk({illegal_out, spec_we_out, file_we_out}, 8'h04);
    idle;
    chk(acc_out, 8'h93);
  endtask
  task automatic t_zero_file;
    op(14'h1900, 8'h00);
    op(14'h0480, 8'h00);
    chk({7'h00, file_we_out}, 8'h01);
    chk(file_wdata_out, 8'h00);
    idle;
    chk({7'h00, zero_flag_out}, 8'h01);
    op(14'h195A, 8'h00);
    idle;
    chk(acc_out, 8'h5A);
    chk({7'h00, zero_flag_out}, 8'h01);
  endtask
  // mid-run reset: values must drop at once, then the core runs again
  task automatic t_reset;
    @(negedge clock_in);
    instr_valid_in = 1'b0;
    arst_n_in = 1'b0;
    #1;
    chk(acc_out, 8'h00);
    chk({7'h00, zero_flag_out}, 8'h00);
    repeat (2) @(posedge clock_in);
    @(negedge clock_in);
    arst_n_in = 1'b1;
    repeat (3) @(posedge clock_in);
    op(14'h1A00, 8'h00);
    op(14'h1A81, 8'h00);
    chk({7'h00, zero_flag_out}, 8'h01);
    idle;
    chk({7'h00, zero_flag_out}, 8'h00);
    chk(acc_out, 8'h81);
  endtask
  initial begin
    arst_n_in = 1'b0;
    instr_valid_in = 1'b0;
    instr_in = 14'h0000;
    file_rdata_in = 8'h00;
    repeat (8) @(posedge clock_in);
    @(negedge clock_in);
    arst_n_in = 1'b1;
    // two sync flops before the registers run
    repeat (3) @(posedge clock_in);
    t_literal;
    t_or_file;
    t_store;
    t_zero_file;
    t_reset;
    end_of_test;
  end
  initial begin
    #5000;
    bad_count++;
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
